// *** rtl/charge_time_pkg.sv ***
// Package: register map, field layout and carrier types of the charge time unit
`default_nettype none
package charge_time_pkg;
    // Byte addresses of the three control words and the status word on the register bus
    localparam logic [3:0]  CTRL_A_ADDR     = 4'h0;
    localparam logic [3:0]  CTRL_B_ADDR     = 4'h4;
    localparam logic [3:0]  CURR_ADDR       = 4'h8;
    localparam logic [3:0]  STATE_ADDR      = 4'hc;
    // Reset values
    localparam logic [15:0] CTRL_A_RESET    = 16'h0000;
    localparam logic [15:0] CTRL_B_RESET    = 16'h0000;
    localparam logic [15:0] CURR_RESET      = 16'h0000;
    // Control A field positions
    localparam int          UNIT_EN_BIT     = 15;
    localparam int          STOP_IDLE_BIT   = 13;
    localparam int          DELAY_GEN_BIT   = 12;
    localparam int          EDGE_GATE_BIT   = 11;
    localparam int          EDGE_ORDER_BIT  = 10;
    localparam int          DISCHARGE_BIT   = 9;
    localparam int          TRIG_EN_BIT     = 8;
    localparam logic [15:0] CTRL_A_MASK     = 16'hbf00;
    // Control B field positions
    localparam int          E1_MODE_BIT     = 15;
    localparam int          E1_POL_BIT      = 14;
    localparam int          E1_SRC_LSB      = 10;
    localparam int          E2_SEEN_BIT     = 9;
    localparam int          E1_SEEN_BIT     = 8;
    localparam int          E2_MODE_BIT     = 7;
    localparam int          E2_POL_BIT      = 6;
    localparam int          E2_SRC_LSB      = 2;
    localparam logic [15:0] CTRL_B_MASK     = 16'hfffc;
    // Current control field positions
    localparam int          TRIM_LSB        = 10;
    localparam int          RANGE_LSB       = 8;
    localparam logic [15:0] CURR_MASK       = 16'hff00;
    // Edge source codes
    localparam logic [3:0]  E1_SRC_PIN_A    = 4'h3;
    localparam logic [3:0]  E1_SRC_PIN_B    = 4'h2;
    localparam logic [3:0]  E1_SRC_OC1      = 4'h1;
    localparam logic [3:0]  E1_SRC_TIMER    = 4'h0;
    localparam logic [3:0]  E2_SRC_PIN_B    = 4'h3;
    localparam logic [3:0]  E2_SRC_PIN_A    = 4'h2;
    localparam logic [3:0]  E2_SRC_CMP2     = 4'h1;
    localparam logic [3:0]  E2_SRC_IC1      = 4'h0;
    localparam logic [1:0]  AXI_OKAY        = 2'h0;
    localparam logic [1:0]  AXI_SLVERR      = 2'h2;

    typedef enum logic [2:0] {
        PH_IDLE   = 3'b001,
        PH_CHARGE = 3'b010,
        PH_DONE   = 3'b100
    } phase_type;

    // Edge source inputs, all asynchronous to the bus clock
    typedef struct packed {
        logic pin_a;
        logic pin_b;
        logic first_timer;
        logic output_compare_one;
        logic input_capture_one;
        logic comparator2;
    } sources_type;

    // Outputs toward the analog current source and pins
    typedef struct packed {
        logic       source_on;
        logic       discharge;
        logic       route_to_cmp2;
        logic       trigger;
        logic [5:0] trim;
        logic [1:0] range;
    } analog_type;
endpackage
`default_nettype wire

// *** rtl/charge_time_unit.sv ***
// Charge time unit control: registers, edge sequencing and pulse logic
// Function
// - Bit 15 of control A switches the edge, charge and delay logic on or off; discharge, trim and range ignore it.
// - Bit 13 set stops the unit while the device idles.
// - Bit 12 enables delay generation, routing current to comparator 2 input B.
// - Delay mode charges on edge, pulses output when comparator trips.
// - Bit 11 gates both edge inputs; cleared blocks edges.
// - Bit 10 set accepts edge 2 only after edge 1.
// - Bit 9 grounds the current source output while set.
// - Bit 8 enables the trigger output.
// - Sample mode bits 15 and 7: one edge, zero level sensitive.
// - Polarity bits 14 and 6: one positive, zero negative response.
// - Edge 1 source: 3 pin A, 2 pin B, 1 compare, 0 timer.
// - Edge 2 source: 3 pin B, 2 pin A, 1 comparator, 0 capture.
// - Status bits 9 and 8 show edges seen; software may write them.
// - Six-bit signed trim adjusts current around nominal.
// - Two-bit range: 11 hundredfold, 10 tenfold, 01 base, 00 reserved.
// - Unimplemented bits read as zero.
// - Pulse edges follow the async source, not the clock.
// - Current source runs between edge 1 and edge 2 events.
`default_nettype none
module charge_time_unit
    import charge_time_pkg::*;
(
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    input  wire logic                         idle_mode_in,
    input  wire charge_time_pkg::sources_type sources_in,
    input  wire logic                         comparator_trip_in,
    output logic                              source_on_async_out,
    output logic                              delay_pulse_out,
    output charge_time_pkg::analog_type       analog_out,
    // AXI4-Lite slave
    input  wire logic [3:0]                   s_axi_awaddr,
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    output logic [1:0]                        s_axi_bresp,
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    input  wire logic [3:0]                   s_axi_araddr,
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready
);
    import charge_time_pkg::*;

    typedef struct packed {
        logic [15:0] ctrl_a;
        logic [15:0] ctrl_b;
        logic [15:0] curr;
        logic [1:0]  e_meta;
        logic [1:0]  e_sync;
        logic [1:0]  e_prev;
        logic [1:0]  trip_sync;
        logic        idle_meta;
        logic        idle_sync;
        phase_type   phase;
        logic        pulse;
        logic [3:0]  aw_addr;
        logic        aw_held;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        w_held;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } state_type;

    state_type state_reg;
    state_type state_next;

    // Edge 1 source multiplexer; reserved codes give a quiet low
    function automatic logic pick_e1(input logic [3:0] sel,
                                     input sources_type s);
        case (sel)
            E1_SRC_PIN_A: pick_e1 = s.pin_a;
            E1_SRC_PIN_B: pick_e1 = s.pin_b;
            E1_SRC_OC1:   pick_e1 = s.output_compare_one;
            E1_SRC_TIMER: pick_e1 = s.first_timer;
            default:      pick_e1 = 1'b0;
        endcase
    endfunction

    function automatic logic pick_e2(input logic [3:0] sel,
                                     input sources_type s);
        case (sel)
            E2_SRC_PIN_B: pick_e2 = s.pin_b;
            E2_SRC_PIN_A: pick_e2 = s.pin_a;
            E2_SRC_CMP2:  pick_e2 = s.comparator2;
            E2_SRC_IC1:   pick_e2 = s.input_capture_one;
            default:      pick_e2 = 1'b0;
        endcase
    endfunction

    // Byte-lane merge of a 16-bit register with a masked write
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0]  strb,
                                          input logic [15:0] mask);
        logic [15:0] v;
        v = old;
        if (strb[0]) v[7:0] = data[7:0];
        if (strb[1]) v[15:8] = data[15:8];
        merge = v & mask;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Raw edge selection and live analog switch
    logic [1:0]  raw;
    logic [1:0]  pol;
    logic [1:0]  mode;
    logic        running;
    logic        gate;
    logic [1:0]  hit;
    logic        wr_fire;
    logic        rd_fire;
    logic [15:0] wr_b;

    always_comb begin
        raw[0] = pick_e1(state_reg.ctrl_b[E1_SRC_LSB +: 4], sources_in);
        raw[1] = pick_e2(state_reg.ctrl_b[E2_SRC_LSB +: 4], sources_in);
        pol    = {state_reg.ctrl_b[E2_POL_BIT], state_reg.ctrl_b[E1_POL_BIT]};
        mode   = {state_reg.ctrl_b[E2_MODE_BIT], state_reg.ctrl_b[E1_MODE_BIT]};
    end

    // Stopped when disabled, or idling with stop-in-idle set
    assign running = state_reg.ctrl_a[UNIT_EN_BIT]
                   & ~(state_reg.ctrl_a[STOP_IDLE_BIT]
                       & state_reg.idle_sync);
    assign gate = running & state_reg.ctrl_a[EDGE_GATE_BIT];

    // Source on from the live edge-1 level until the live edge-2 level,
    // so pulse width is not quantised to the clock; level sensing only
    assign source_on_async_out = gate
        & ~state_reg.ctrl_a[DISCHARGE_BIT]
        & ((raw[0] ~^ pol[0]) | state_reg.ctrl_b[E1_SEEN_BIT])
        & ~((raw[1] ~^ pol[1]) | state_reg.ctrl_b[E2_SEEN_BIT]);
    // Comparator trip reaches the pin without the clock as well
    assign delay_pulse_out = state_reg.pulse
        | (comparator_trip_in & state_reg.phase == PH_CHARGE
           & state_reg.ctrl_a[DELAY_GEN_BIT]);

    ////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        state_next = state_reg;
        state_next.e_meta    = {raw[1], raw[0]};
        state_next.e_sync    = state_reg.e_meta;
        state_next.e_prev    = state_reg.e_sync;
        state_next.trip_sync = {state_reg.trip_sync[0], comparator_trip_in};
        state_next.idle_meta = idle_mode_in;
        state_next.idle_sync = state_reg.idle_meta;

        for (int i = 0; i < 2; i++) begin
            if (mode[i])
                hit[i] = (state_reg.e_sync[i] ^ state_reg.e_prev[i])
                       & (state_reg.e_sync[i] == pol[i]);
            else
                hit[i] = (state_reg.e_sync[i] == pol[i]);
            hit[i] = hit[i] & gate;
        end
        if (state_reg.ctrl_a[EDGE_ORDER_BIT] & ~state_reg.ctrl_b[E1_SEEN_BIT])
            hit[1] = 1'b0;

        // Sticky status set by hardware
        if (hit[0]) state_next.ctrl_b[E1_SEEN_BIT] = 1'b1;
        if (hit[1]) state_next.ctrl_b[E2_SEEN_BIT] = 1'b1;

        // Delay generation phases
        state_next.pulse = 1'b0;
        case (state_reg.phase)
            PH_IDLE: begin
                if (state_reg.ctrl_a[DELAY_GEN_BIT] & hit[0])
                    state_next.phase = PH_CHARGE;
            end
            PH_CHARGE: begin
                if (~state_reg.ctrl_a[DELAY_GEN_BIT] | ~running)
                    state_next.phase = PH_IDLE;
                else if (state_reg.trip_sync[1]) begin
                    state_next.phase = PH_DONE;
                    state_next.pulse = 1'b1;
                end
            end
            PH_DONE: begin
                if (~state_reg.trip_sync[1])
                    state_next.phase = PH_IDLE;
            end
            default: state_next.phase = PH_IDLE;
        endcase

        // AXI write channel: address and data in either order
        if (s_axi_awvalid & ~state_reg.aw_held) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~state_reg.w_held) begin
            state_next.w_held = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        wr_fire = state_reg.aw_held & state_reg.w_held & ~state_reg.bvalid;
        wr_b = merge(state_reg.ctrl_b, state_reg.w_data, state_reg.w_strb,
                     CTRL_B_MASK);
        if (wr_fire) begin
            state_next.aw_held = 1'b0;
            state_next.w_held  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = AXI_OKAY;
            case (state_reg.aw_addr)
                CTRL_A_ADDR: state_next.ctrl_a = merge(state_reg.ctrl_a,
                    state_reg.w_data, state_reg.w_strb, CTRL_A_MASK);
                CTRL_B_ADDR: begin
                    // A write of the status byte wins over a fresh edge
                    if (state_reg.w_strb[1])
                        state_next.ctrl_b = wr_b;
                    else
                        state_next.ctrl_b = {state_next.ctrl_b[15:8],
                                             wr_b[7:0]};
                end
                CURR_ADDR: state_next.curr = merge(state_reg.curr,
                    state_reg.w_data, state_reg.w_strb, CURR_MASK);
                STATE_ADDR: state_next.bresp = AXI_SLVERR;
                default: state_next.bresp = AXI_SLVERR;
            endcase
        end
        if (state_reg.bvalid & s_axi_bready)
            state_next.bvalid = 1'b0;

        // AXI read channel
        rd_fire = s_axi_arvalid & ~state_reg.rvalid;
        if (rd_fire) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = AXI_OKAY;
            case (s_axi_araddr)
                CTRL_A_ADDR: state_next.rdata = {16'h0000, state_reg.ctrl_a};
                CTRL_B_ADDR: state_next.rdata = {16'h0000, state_reg.ctrl_b};
                CURR_ADDR:   state_next.rdata = {16'h0000, state_reg.curr};
                STATE_ADDR:  state_next.rdata = {28'h0000000,
                    running, state_reg.phase};
                default: begin
                    state_next.rdata = 32'h00000000;
                    state_next.rresp = AXI_SLVERR;
                end
            endcase
        end
        if (state_reg.rvalid & s_axi_rready)
            state_next.rvalid = 1'b0;
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            state_reg        <= '0;
            state_reg.ctrl_a <= CTRL_A_RESET;
            state_reg.ctrl_b <= CTRL_B_RESET;
            state_reg.curr   <= CURR_RESET;
            state_reg.phase  <= PH_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Outputs
    assign s_axi_awready = ~state_reg.aw_held;
    assign s_axi_wready  = ~state_reg.w_held;
    assign s_axi_bvalid  = state_reg.bvalid;
    assign s_axi_bresp   = state_reg.bresp;
    assign s_axi_arready = ~state_reg.rvalid;
    assign s_axi_rvalid  = state_reg.rvalid;
    assign s_axi_rdata   = state_reg.rdata;
    assign s_axi_rresp   = state_reg.rresp;

    always_comb begin
        analog_out.source_on     = source_on_async_out;
        analog_out.discharge     = state_reg.ctrl_a[DISCHARGE_BIT];
        analog_out.route_to_cmp2 = running
                                 & state_reg.ctrl_a[DELAY_GEN_BIT];
        analog_out.trigger       = running
                                 & state_reg.ctrl_a[TRIG_EN_BIT]
                                 & state_reg.ctrl_b[E2_SEEN_BIT];
        analog_out.trim          = state_reg.curr[TRIM_LSB +: 6];
        analog_out.range         = state_reg.curr[RANGE_LSB +: 2];
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    chk_disabled_no_edge: assert property (@(posedge clk_in) disable iff (rst_in)
        !$past(state_reg.ctrl_a[UNIT_EN_BIT]) && !$past(rst_in)
        && !$past(wr_fire) |-> $stable(state_reg.ctrl_b[9:8]))
        else $error("edge status moved while unit disabled");
    chk_order_edge2: assert property (@(posedge clk_in) disable iff (rst_in)
        state_reg.ctrl_a[EDGE_ORDER_BIT] && !state_reg.ctrl_b[E1_SEEN_BIT]
        && !wr_fire |=> !$rose(state_reg.ctrl_b[E2_SEEN_BIT]))
        else $error("edge 2 accepted before edge 1");
    chk_sticky_seen: assert property (@(posedge clk_in) disable iff (rst_in)
        state_reg.ctrl_b[E1_SEEN_BIT] && !wr_fire
        |=> state_reg.ctrl_b[E1_SEEN_BIT])
        else $error("edge 1 status dropped without a write");
    chk_gate_blocks: assert property (@(posedge clk_in) disable iff (rst_in)
        !state_reg.ctrl_a[EDGE_GATE_BIT] && !wr_fire
        |=> $stable(state_reg.ctrl_b[9:8]))
        else $error("edge passed while edges blocked");
    chk_pulse_after_trip: assert property (@(posedge clk_in) disable iff (rst_in)
        state_reg.phase == PH_CHARGE && state_reg.trip_sync[1]
        && running && state_reg.ctrl_a[DELAY_GEN_BIT]
        |=> state_reg.pulse ##1 !state_reg.pulse)
        else $error("delay pulse missing after trip");
    chk_discharge_pin: assert property (@(posedge clk_in) disable iff (rst_in)
        analog_out.discharge |-> !source_on_async_out)
        else $error("source on while grounded");
    chk_unused_zero: assert property (@(posedge clk_in) disable iff (rst_in)
        (state_reg.ctrl_a & ~CTRL_A_MASK) == 16'h0000
        && state_reg.ctrl_b[1:0] == 2'h0 && state_reg.curr[7:0] == 8'h00)
        else $error("unimplemented bits set");
    chk_read_answer: assert property (@(posedge clk_in) disable iff (rst_in)
        rd_fire |=> s_axi_rvalid)
        else $error("read not answered next cycle");
endmodule
`default_nettype wire

// *** tb/edge_timed_current_source_ctrl_test.sv ***
// Testbench for the charge time unit: registers, edges and delay pulse
`default_nettype none
module edge_timed_current_source_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import charge_time_pkg::*;
    logic        clk_in, rst_in, idle_mode_in, comparator_trip_in;
    logic        source_on_async_out, delay_pulse_out;
    sources_type sources_in, want;
    analog_type  analog_out;
    logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready;
    int          fails, tests_run, budget;
    ////////////////////////////////////////////////////////////////////////
    charge_time_unit dut (
        .clk_in, .rst_in, .idle_mode_in, .sources_in, .comparator_trip_in,
        .source_on_async_out, .delay_pulse_out, .analog_out,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready
    );
    far_side_model far (
        .clk_in, .rst_in, .want_in(want), .analog_in(analog_out),
        .charging_in(source_on_async_out), .sources_out(sources_in),
        .trip_out(comparator_trip_in)
    );
    initial begin
        clk_in = 1'b0;
        forever #10 clk_in = ~clk_in;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Every handshake wait goes through here, so a hang ends the run
    task automatic step();
        @(posedge clk_in);
        budget++;
        if (budget > 300) begin
            $display("Error handshake expected answer seen none");
            fails++;
            stop_test();
        end
    endtask
    task automatic check(input string what, input logic [31:0] exp,
                         input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d,
                      input logic [1:0] resp);
        logic aw_done, w_done;
        budget = 0;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge clk_in);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= {16'h0000, d};
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_done && w_done)) begin
            step();
            if (s_axi_awvalid && s_axi_awready) begin
                aw_done = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_done = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        while (s_axi_bvalid !== 1'b1) step();
        check("write response", resp, s_axi_bresp);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_chk(input string what, input logic [3:0] a,
                          input logic [15:0] exp);
        budget = 0;
        @(posedge clk_in);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        step();
        while (!(s_axi_arvalid && s_axi_arready)) step();
        s_axi_arvalid <= 1'b0;
        while (s_axi_rvalid !== 1'b1) step();
        check(what, {16'h0000, exp}, s_axi_rdata);
        check("read response", (a inside {CTRL_A_ADDR, CTRL_B_ADDR,
              CURR_ADDR, STATE_ADDR}) ? AXI_OKAY : AXI_SLVERR, s_axi_rresp);
        s_axi_rready <= 1'b0;
    endtask
    // Two sync flops, hit, then status: eight edges leave margin
    task automatic drive(input logic [5:0] s);
        @(posedge clk_in);
        want <= s;
        repeat (8) @(posedge clk_in);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_fields();
        rd_chk("control a", CTRL_A_ADDR, 16'h0000);
        rd_chk("control b", CTRL_B_ADDR, 16'h0000);
        rd_chk("current", CURR_ADDR, 16'h0000);
        rd_chk("status", STATE_ADDR, 16'h0001);
        rd_chk("unmapped", 4'h2, 16'h0000);
        wr(CTRL_A_ADDR, 16'hffff, AXI_OKAY);
        wr(CTRL_B_ADDR, 16'hffff, AXI_OKAY);
        wr(CURR_ADDR, 16'hffff, AXI_OKAY);
        wr(STATE_ADDR, 16'hffff, AXI_SLVERR);
        rd_chk("control a", CTRL_A_ADDR, 16'hbf00);
        rd_chk("control b", CTRL_B_ADDR, 16'hfffc);
        rd_chk("current", CURR_ADDR, 16'hff00);
        check("discharge", 1, analog_out.discharge);
        check("route", 1, analog_out.route_to_cmp2);
        check("trigger", 1, analog_out.trigger);
        check("trim range", 8'hff, {analog_out.trim, analog_out.range});
        wr(CTRL_A_ADDR, 16'h0000, AXI_OKAY);
        check("discharge", 0, analog_out.discharge);
        $display("Test fields done");
    endtask
    task automatic test_sources();
        int          e1_bit[4] = '{3, 2, 4, 5};
        int          e2_bit[4] = '{1, 0, 5, 4};
        logic [15:0] b;
        wr(CTRL_A_ADDR, 16'h8800, AXI_OKAY);
        for (int c = 0; c < 4; c++) begin
            b = 16'h4040 | (16'(c) << 10) | (16'(c) << 2);
            drive(6'h00);
            wr(CTRL_B_ADDR, b, AXI_OKAY);
            drive(6'h01 << e1_bit[c]);
            rd_chk("edge1 seen", CTRL_B_ADDR, b | 16'h0100);
            check("source on", 1, source_on_async_out);
            drive((6'h01 << e1_bit[c]) | (6'h01 << e2_bit[c]));
            rd_chk("edge2 seen", CTRL_B_ADDR, b | 16'h0300);
            check("source off", 0, source_on_async_out);
            check("trigger off", 0, analog_out.trigger);
        end
        $display("Test sources done");
    endtask
    task automatic test_edges();
        drive(6'h30);
        wr(CTRL_A_ADDR, 16'h8900, AXI_OKAY);
        wr(CTRL_B_ADDR, 16'h8ccc, AXI_OKAY);
        drive(6'h30);
        rd_chk("steady levels", CTRL_B_ADDR, 16'h8ccc);
        drive(6'h10);
        rd_chk("falling edge1", CTRL_B_ADDR, 16'h8dcc);
        check("trigger held", 0, analog_out.trigger);
        drive(6'h00);
        drive(6'h10);
        rd_chk("rising edge2", CTRL_B_ADDR, 16'h8fcc);
        check("trigger", 1, analog_out.trigger);
        $display("Test edges done");
    endtask
    task automatic test_order();
        drive(6'h00);
        wr(CTRL_A_ADDR, 16'h8c00, AXI_OKAY);
        wr(CTRL_B_ADDR, 16'h4c4c, AXI_OKAY);
        drive(6'h10);
        rd_chk("edge2 held back", CTRL_B_ADDR, 16'h4c4c);
        drive(6'h30);
        rd_chk("edges in order", CTRL_B_ADDR, 16'h4f4c);
        drive(6'h00);
        rd_chk("status sticks", CTRL_B_ADDR, 16'h4f4c);
        wr(CTRL_B_ADDR, 16'h4c4c, AXI_OKAY);
        rd_chk("status cleared", CTRL_B_ADDR, 16'h4c4c);
        $display("Test order done");
    endtask
    task automatic test_blocking();
        logic [15:0] a_val[5] = '{16'h8000, 16'h0800, 16'ha800, 16'h8800,
                                  16'ha800};
        logic        idle[5] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
        logic [15:0] exp[5] = '{16'h4c4c, 16'h4c4c, 16'h4c4c, 16'h4d4c,
                                16'h4d4c};
        for (int k = 0; k < 5; k++) begin
            drive(6'h00);
            idle_mode_in <= idle[k];
            wr(CTRL_A_ADDR, a_val[k], AXI_OKAY);
            wr(CTRL_B_ADDR, 16'h4c4c, AXI_OKAY);
            drive(6'h20);
            rd_chk("gated edge", CTRL_B_ADDR, exp[k]);
        end
        idle_mode_in <= 1'b0;
        $display("Test blocking done");
    endtask
    task automatic test_delay();
        logic seen;
        seen = 1'b0;
        drive(6'h00);
        // Status cleared first so no stale edge charges the capacitor
        wr(CTRL_B_ADDR, 16'hcc40, AXI_OKAY);
        wr(CTRL_A_ADDR, 16'h0200, AXI_OKAY);
        wr(CTRL_A_ADDR, 16'h9800, AXI_OKAY);
        check("route", 1, analog_out.route_to_cmp2);
        check("pulse quiet", 0, delay_pulse_out);
        drive(6'h20);
        repeat (100) begin
            @(posedge clk_in);
            seen = seen | (delay_pulse_out === 1'b1);
        end
        check("delay pulse", 1, seen);
        rd_chk("phase done", STATE_ADDR, 16'h000c);
        $display("Test delay done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {fails, tests_run, budget} = '0;
        rst_in = 1'b1;
        idle_mode_in = 1'b0;
        want = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        test_fields();
        test_sources();
        test_edges();
        test_order();
        test_blocking();
        test_delay();
        stop_test();
    end
endmodule
`default_nettype wire

// *** tb/far_side_model.sv ***
// Far side model: edge sources and comparator 2 charging a capacitor
`default_nettype none
module far_side_model #(
    parameter int TRIP_LEVEL = 12
) (
    input  wire logic                         clk_in,
    input  wire logic                         rst_in,
    input  wire charge_time_pkg::sources_type want_in,
    input  wire charge_time_pkg::analog_type  analog_in,
    input  wire logic                         charging_in,
    output var charge_time_pkg::sources_type  sources_out,
    output logic                              trip_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import charge_time_pkg::*;
    int unsigned level_reg;
    ////////////////////////////////////////////////////////////////////////
    // Peripheral outputs move just after an edge, like the real ones
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            sources_out <= '0;
        end else begin
            sources_out <= want_in;
        end
    end
    // Capacitor voltage as a count; discharge empties it at once
    always_ff @(posedge clk_in) begin
        if (rst_in || analog_in.discharge) begin
            level_reg <= 0;
        end else if (analog_in.route_to_cmp2 && charging_in) begin
            level_reg <= level_reg + 1;
        end
    end
    // Stays tripped until discharged, so a late sample still sees it
    assign trip_out = (level_reg >= TRIP_LEVEL);
endmodule
`default_nettype wire
